/* File: logic/fprs_params.svh */
/*
 * Constants shared by both ends of the page refresh and status link:
 * opcodes, address layout, status bit positions, timing and the host's
 * own register map.
 * Assumes it is included by bare name after the package, at file scope before the modules.
 */
`ifndef FPRS_PARAMS_SVH
`define FPRS_PARAMS_SVH

// ****************************************************************
// Opcodes
// ****************************************************************
`define FPRS_OP_REFRESH_BUF1 8'h58
`define FPRS_OP_REFRESH_BUF2 8'h59
`define FPRS_OP_STATUS       8'hd7

// ****************************************************************
// Frame layout, in serial clock bits
// ****************************************************************
`define FPRS_OPCODE_BITS     6'h08
`define FPRS_HEADER_BITS     6'h20
`define FPRS_HEADER_LAST     6'h27
`define FPRS_PAGE_MSB_264    19
`define FPRS_PAGE_MSB_256    18

// ****************************************************************
// Status bit positions
// ****************************************************************
`define FPRS_ST_READY        7
`define FPRS_ST_COMP         6
`define FPRS_ST_FAULT        5

// ****************************************************************
// Timing: core clock 250 MHz, self-timed limit in microseconds
// ****************************************************************
`define FPRS_CLK_MHZ         250
`define FPRS_REWRITE_LIMIT_US 20
`define FPRS_SCLK_HALF       4'h2

// ****************************************************************
// Host register map (byte addresses) and control fields
// ****************************************************************
`define FPRS_REG_CTRL        8'h00
`define FPRS_REG_PAGE        8'h04
`define FPRS_REG_STATUS      8'h08
`define FPRS_CTRL_GO         0
`define FPRS_CTRL_KIND       1
`define FPRS_CTRL_BUFFER     2
`define FPRS_CTRL_SIZE256    3

`endif

/* File: logic/fprs_pkg.sv */
/*
 * Types shared by both ends of the page refresh and status link.
 * Assumes nothing of its surroundings.
 */
package fprs_pkg;

   // ****************************************************************
   // Device command decoder states, Gray coded.
   // ****************************************************************
   typedef enum logic [1:0] {
      FPRS_CMD_OPCODE  = 2'h0,
      FPRS_CMD_REFRESH = 2'h1,
      FPRS_CMD_STATUS  = 2'h3,
      FPRS_CMD_IGNORE  = 2'h2
   } fprs_cmd_type;

   // ****************************************************************
   // Host sequencer states, Gray coded.
   // ****************************************************************
   typedef enum logic [1:0] {
      FPRS_HOST_IDLE  = 2'h0,
      FPRS_HOST_SHIFT = 2'h1,
      FPRS_HOST_TAIL  = 2'h3,
      FPRS_HOST_END   = 2'h2
   } fprs_host_type;

endpackage : fprs_pkg

/* File: logic/fprs_link_if.sv */
/*
 * Serial link between the host and the flash device end.
 * Assumes both ends run on the same core clock; the testbench joins them.
 */
`timescale 1ns/1ps

interface fprs_link_if;
   logic sclk;      // Serial clock, idle low.
   logic cs_n;      // Chip select, active low.
   logic mosi;      // Host to device data.
   logic miso;      // Device output value.
   logic miso_oe;   // Device drives the output while high.
   wire  miso_line; // Output as the host sees it.

   // There is no pull on the line, so a released output shows the inverse of the
   // last bit; a host that samples outside a driven window then sees wrong data.
   assign miso_line = miso_oe ? miso : !miso;

   modport dev  (input sclk, input cs_n, input mosi, output miso, output miso_oe);
   modport host (output sclk, output cs_n, output mosi, input miso_line);
endinterface : fprs_link_if

/* File: logic/fprs_device.sv */
/*
 * Device end: decodes page refresh and status read commands from the
 * serial link, times the self-timed refresh and streams the status pair.
 * Assumes link inputs are synchronous to core_clk and that the serial
 * clock half period spans at least two core clocks.
 */
`timescale 1ns/1ps

`include "fprs_params.svh"

// Summary of operation
// - Opcodes 58h/59h select refresh buffer one/two.
// - 264 layout: four dummy, page, nine dummy.
// - 256 layout: five dummy, page, eight dummy.
// - Chip select rise starts copy and program back.
// - Refresh self-timed, busy throughout, bounded time.
// - Trailing data bytes turn refresh into read-modify-write.
// - Host rewrites static pages every 50,000 operations; fprs_host keeps no count and refreshes only on a register order.
// - Opcode D7h then status bits every cycle.
// - Status pair repeats, each repetition current.
// - Status read accepted even while busy.
// - Chip select high releases output at once.
// - Bit 7 ready, sampled per byte.
// - First byte bit 6 compare mismatch.
// - First byte bits 5:2 fixed size code.
// - First byte bit 1 protection enabled.
// - First byte bit 0 page size.
// - Second byte bit 5 erase/program fault.
// - Fault refreshed per operation, cleared on abort.
// - Second byte bits 6,4,3 read zero.
// - Host polls until ready goes one.
// - Compare completion updates bit 6, busy meanwhile.
module fprs_device
   import fprs_pkg::*;
#(
   parameter int unsigned REWRITE_CYCLES = `FPRS_REWRITE_LIMIT_US * `FPRS_CLK_MHZ,
   parameter logic [3:0]  SIZE_CODE      = 4'h5 // Arbitrary value.
)(
   input  wire logic        core_clk,
   input  wire logic        rst,
   fprs_link_if.dev         link,
   input  wire logic        page_size_256,
   input  wire logic        protect_enabled,
   input  wire logic        array_abort,
   input  wire logic        array_fault,
   input  wire logic        compare_busy,
   input  wire logic        compare_done,
   input  wire logic        compare_mismatch,
   output logic             refresh_start,
   output logic             refresh_done,
   output logic             refresh_buffer,
   output logic             refresh_rmw,
   output logic [10:0]      refresh_page,
   output logic             busy
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   fprs_cmd_type cmd;          // Decoder state of the current frame.
   logic         sclk_q;       // Serial clock one core cycle ago.
   logic         cs_n_q;       // Chip select one core cycle ago.
   logic         rise;         // Serial clock rising edge inside a frame.
   logic         fall;         // Serial clock falling edge inside a frame.
   logic         frame_end;    // Chip select rising edge.
   logic [5:0]   bit_cnt;      // Bits taken in this frame, wraps in data.
   logic [7:0]   opcode_sr;    // Opcode shift register.
   logic [23:0]  addr_sr;      // Address bytes shift register.
   logic [7:0]   next_opcode;  // Opcode including the bit now arriving.
   logic         buffer_sel;   // Buffer named by the opcode.
   logic         data_seen;    // A data bit followed the address.
   logic [31:0]  timer;        // Refresh cycles remaining.
   logic         refreshing;   // Self-timed refresh in progress.
   logic         comp_flag;    // Latest compare outcome.
   logic         fault_flag;   // Latest erase/program outcome.
   logic [3:0]   out_idx;      // Position within the status pair.
   logic [7:0]   out_sr;       // Remaining bits of the byte being sent.
   logic [7:0]   fresh_byte;   // Status byte sampled now.
   logic         miso_q;       // Registered output bit.
   logic         drive_q;      // Output enabled for this frame.

   assign rise        = !link.cs_n && link.sclk && !sclk_q;
   assign fall        = !link.cs_n && !link.sclk && sclk_q;
   assign frame_end   = link.cs_n && !cs_n_q;
   assign next_opcode = {opcode_sr[6:0], link.mosi};
   assign busy        = refreshing || compare_busy;

   // Ready is taken live, so every byte of every repetition is current.
   always_comb begin
      if (out_idx[3]) begin
         fresh_byte = {!busy, 1'b0, fault_flag, 3'h0, 2'h0};
      end else begin
         fresh_byte = {!busy, comp_flag, SIZE_CODE, protect_enabled,
                       page_size_256};
      end
   end

   // ****************************************************************
   // Link edge detection
   // ****************************************************************

   // Previous samples of the link clock and select.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sclk_q <= 1'b0;
         cs_n_q <= 1'b1;
      end else begin
         sclk_q <= link.sclk;
         cs_n_q <= link.cs_n;
      end
   end

   // ****************************************************************
   // Command shifting and decode
   // ****************************************************************

   // Bit counter; past the header it wraps over one byte so the byte
   // alignment of chip select can still be judged.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         bit_cnt <= 6'h00;
      end else if (link.cs_n) begin
         bit_cnt <= 6'h00;
      end else if (rise) begin
         bit_cnt <= (bit_cnt == `FPRS_HEADER_LAST) ? `FPRS_HEADER_BITS : bit_cnt + 6'h01;
      end
   end

   // Opcode and address capture, most significant bit first.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         opcode_sr <= 8'h00;
         addr_sr   <= 24'h000000;
      end else if (rise && bit_cnt < `FPRS_OPCODE_BITS) begin
         opcode_sr <= next_opcode;
      end else if (rise && bit_cnt < `FPRS_HEADER_BITS) begin
         addr_sr <= {addr_sr[22:0], link.mosi};
      end
   end

   // Decoder state. Status is accepted whatever the busy state; a refresh
   // while busy is ignored so the running one is not disturbed.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cmd        <= FPRS_CMD_OPCODE;
         buffer_sel <= 1'b0;
      end else if (link.cs_n) begin
         cmd <= FPRS_CMD_OPCODE;
      end else if (rise && bit_cnt == `FPRS_OPCODE_BITS - 6'h01) begin
         if (next_opcode == `FPRS_OP_STATUS) begin
            cmd <= FPRS_CMD_STATUS;
         end else if (next_opcode == `FPRS_OP_REFRESH_BUF1 && !busy) begin
            cmd        <= FPRS_CMD_REFRESH;
            buffer_sel <= 1'b0;
         end else if (next_opcode == `FPRS_OP_REFRESH_BUF2 && !busy) begin
            cmd        <= FPRS_CMD_REFRESH;
            buffer_sel <= 1'b1;
         end else begin
            cmd <= FPRS_CMD_IGNORE;
         end
      end
   end

   // Any bit after the address marks the frame as read-modify-write.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         data_seen <= 1'b0;
      end else if (link.cs_n) begin
         data_seen <= 1'b0;
      end else if (rise && bit_cnt >= `FPRS_HEADER_BITS) begin
         data_seen <= 1'b1;
      end
   end

   // ****************************************************************
   // Self-timed refresh
   // ****************************************************************

   // Start on chip select rise after a whole header ending on a byte
   // boundary; run for the time limit unless the array aborts.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         refreshing     <= 1'b0;
         timer          <= 32'h00000000;
         refresh_start  <= 1'b0;
         refresh_done   <= 1'b0;
         refresh_buffer <= 1'b0;
         refresh_rmw    <= 1'b0;
         refresh_page   <= 11'h000;
      end else begin
         refresh_start <= 1'b0;
         refresh_done  <= 1'b0;
         if (frame_end && cmd == FPRS_CMD_REFRESH && bit_cnt >= `FPRS_HEADER_BITS
             && bit_cnt[2:0] == 3'h0) begin
            refreshing     <= 1'b1;
            timer          <= REWRITE_CYCLES - 1;
            refresh_start  <= 1'b1;
            refresh_buffer <= buffer_sel;
            refresh_rmw    <= data_seen;
            if (page_size_256) begin
               refresh_page <= addr_sr[`FPRS_PAGE_MSB_256 -: 11];
            end else begin
               refresh_page <= addr_sr[`FPRS_PAGE_MSB_264 -: 11];
            end
         end else if (refreshing && (timer == 32'h00000000 || array_abort)) begin
            refreshing   <= 1'b0;
            refresh_done <= 1'b1;
         end else if (refreshing) begin
            timer <= timer - 32'h00000001;
         end
      end
   end

   // ****************************************************************
   // Status flags
   // ****************************************************************

   // Fault follows each finished refresh; an aborted one never sets it.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         fault_flag <= 1'b0;
      end else if (refreshing && array_abort) begin
         fault_flag <= 1'b0;
      end else if (refreshing && timer == 32'h00000000) begin
         fault_flag <= array_fault;
      end
   end

   // Compare outcome is taken only when the compare completes.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         comp_flag <= 1'b0;
      end else if (compare_done) begin
         comp_flag <= compare_mismatch;
      end
   end

   // ****************************************************************
   // Status stream
   // ****************************************************************

   // On each falling edge send the next bit; at a byte start take a fresh
   // sample, so the pair repeats with live contents.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         out_idx <= 4'h0;
         out_sr  <= 8'h00;
         miso_q  <= 1'b0;
         drive_q <= 1'b0;
      end else if (link.cs_n) begin
         out_idx <= 4'h0;
         drive_q <= 1'b0;
      end else if (fall && cmd == FPRS_CMD_STATUS) begin
         drive_q <= 1'b1;
         out_idx <= out_idx + 4'h1;
         if (out_idx[2:0] == 3'h0) begin
            miso_q <= fresh_byte[7];
            out_sr <= {fresh_byte[6:0], 1'b0};
         end else begin
            miso_q <= out_sr[7];
            out_sr <= {out_sr[6:0], 1'b0};
         end
      end
   end

   assign link.miso    = miso_q;
   // Gated by the live select so the release needs no clock edge.
   assign link.miso_oe = drive_q && !link.cs_n;

endmodule : fprs_device

/* File: logic/fprs_host.sv */
/*
 * Host end: a register port takes refresh and status poll orders and
 * runs them over the serial link in SPI mode 0.
 * Assumes the device samples link pins on the same core clock.
 */
`timescale 1ns/1ps

`include "fprs_params.svh"

module fprs_host
   import fprs_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst,
   fprs_link_if.host        link,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   output logic [31:0]      reg_rdata
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   fprs_host_type state;      // Sequencer state.
   logic          kind_status; // Order is a status poll.
   logic          buffer_sel;  // Refresh buffer select.
   logic          size_256;    // Page layout to encode.
   logic [10:0]   page;        // Page to refresh.
   logic [31:0]   tx_sr;       // Outgoing bits.
   logic [5:0]    tx_left;     // Outgoing bits still to clock.
   logic [3:0]    half_cnt;    // Core cycles left in this half period.
   logic [15:0]   rx_sr;       // Incoming status bits.
   logic [3:0]    rx_cnt;      // Status bits taken in this pair.
   logic          rx_on;       // Opcode sent, status arriving.
   logic [15:0]   status_pair; // Last whole status pair.
   logic          sclk_q;      // Driven serial clock.
   logic          start;       // Go written while idle.

   assign start     = reg_write && reg_addr == `FPRS_REG_CTRL
                      && reg_wdata[`FPRS_CTRL_GO] && state == FPRS_HOST_IDLE;
   assign link.sclk = sclk_q;

   // ****************************************************************
   // Registers
   // ****************************************************************

   // Order fields. A go written while busy is dropped.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         kind_status <= 1'b0;
         buffer_sel  <= 1'b0;
         size_256    <= 1'b0;
         page        <= 11'h000;
      end else if (reg_write && reg_addr == `FPRS_REG_PAGE) begin
         page <= reg_wdata[10:0];
      end else if (reg_write && reg_addr == `FPRS_REG_CTRL) begin
         kind_status <= reg_wdata[`FPRS_CTRL_KIND];
         buffer_sel  <= reg_wdata[`FPRS_CTRL_BUFFER];
         size_256    <= reg_wdata[`FPRS_CTRL_SIZE256];
      end
   end

   // Read data one cycle after the strobe; unmapped reads return zero.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_read && reg_addr == `FPRS_REG_CTRL) begin
         reg_rdata <= {28'h0000000, size_256, buffer_sel, kind_status,
                       state != FPRS_HOST_IDLE};
      end else if (reg_read && reg_addr == `FPRS_REG_PAGE) begin
         reg_rdata <= {21'h000000, page};
      end else if (reg_read && reg_addr == `FPRS_REG_STATUS) begin
         reg_rdata <= {16'h0000, status_pair};
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end

   // ****************************************************************
   // Serial sequencer
   // ****************************************************************

   // Mode 0: data set while the clock is low, sampled on its rise. A
   // poll keeps clocking until a whole pair ends with its first byte showing ready.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state       <= FPRS_HOST_IDLE;
         link.cs_n   <= 1'b1;
         link.mosi   <= 1'b0;
         sclk_q      <= 1'b0;
         tx_sr       <= 32'h00000000;
         tx_left     <= 6'h00;
         half_cnt    <= 4'h0;
         rx_sr       <= 16'h0000;
         rx_cnt      <= 4'h0;
         rx_on       <= 1'b0;
         status_pair <= 16'h0000;
      end else begin
         unique case (state)
            FPRS_HOST_IDLE: begin
               if (start) begin
                  if (reg_wdata[`FPRS_CTRL_KIND]) begin
                     tx_sr   <= {`FPRS_OP_STATUS, 24'h000000};
                     tx_left <= `FPRS_OPCODE_BITS;
                  end else if (reg_wdata[`FPRS_CTRL_SIZE256]) begin
                     tx_sr <= {reg_wdata[`FPRS_CTRL_BUFFER] ? `FPRS_OP_REFRESH_BUF2
                               : `FPRS_OP_REFRESH_BUF1, 5'h00, page, 8'h00};
                     tx_left <= `FPRS_HEADER_BITS;
                  end else begin
                     tx_sr <= {reg_wdata[`FPRS_CTRL_BUFFER] ? `FPRS_OP_REFRESH_BUF2
                               : `FPRS_OP_REFRESH_BUF1, 4'h0, page, 9'h000};
                     tx_left <= `FPRS_HEADER_BITS;
                  end
                  link.cs_n <= 1'b0;
                  rx_on     <= 1'b0;
                  rx_cnt    <= 4'h0;
                  half_cnt  <= `FPRS_SCLK_HALF;
                  state     <= FPRS_HOST_SHIFT;
               end
            end
            FPRS_HOST_SHIFT: begin
               // Data moves only while the clock is low, never under a high clock.
               if (!sclk_q) begin
                  link.mosi <= tx_sr[31];
               end
               if (half_cnt != 4'h1) begin
                  half_cnt <= half_cnt - 4'h1;
               end else if (!sclk_q) begin
                  sclk_q   <= 1'b1;
                  half_cnt <= `FPRS_SCLK_HALF;
                  if (rx_on) begin
                     rx_sr  <= {rx_sr[14:0], link.miso_line};
                     rx_cnt <= rx_cnt + 4'h1;
                  end else begin
                     tx_left <= tx_left - 6'h01;
                     tx_sr   <= {tx_sr[30:0], 1'b0};
                  end
               end else begin
                  sclk_q   <= 1'b0;
                  half_cnt <= `FPRS_SCLK_HALF;
                  if (rx_on && rx_cnt == 4'h0) begin
                     status_pair <= rx_sr;
                     // Ready of the first byte is the older sample of the pair.
                     if (rx_sr[`FPRS_ST_READY + 8]) begin
                        state <= FPRS_HOST_TAIL;
                     end
                  end else if (!rx_on && tx_left == 6'h00) begin
                     if (kind_status) begin
                        rx_on <= 1'b1;
                     end else begin
                        state <= FPRS_HOST_TAIL;
                     end
                  end
               end
            end
            FPRS_HOST_TAIL: begin
               link.cs_n <= 1'b1;
               half_cnt  <= `FPRS_SCLK_HALF;
               state     <= FPRS_HOST_END;
            end
            FPRS_HOST_END: begin
               // Hold chip select high a half period before the next frame.
               if (half_cnt == 4'h1) begin
                  state <= FPRS_HOST_IDLE;
               end else begin
                  half_cnt <= half_cnt - 4'h1;
               end
            end
         endcase
      end
   end

endmodule : fprs_host

/* File: test/fprs_sva.sv */
/* Link checker: framing, output release and shift timing on the serial wire.
   Assumes one core clock; the testbench wires in the link interface signals. */
`timescale 1ns/1ps
module fprs_sva (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic miso,
   input wire logic miso_oe
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   logic [7:0] rises; // Serial rises in this frame; framing is rebuilt from the wire.
   logic [7:0] op;    // First byte of the frame.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rises <= 8'h00;
         op    <= 8'h00;
      end else if (cs_n) begin
         rises <= 8'h00;
      end else if ($rose(sclk)) begin
         rises <= rises + 8'h01;
         if (rises < 8'h08) op <= {op[6:0], mosi};
      end
   end
   a_cs_releases_out: assert property (cs_n |-> !miso_oe)
      else $error("output driven while deselected");
   a_status_drives: assert property (op == 8'hd7 && rises > 8'h08 && !cs_n |-> miso_oe)
      else $error("status read not driving");
   a_refresh_silent: assert property ((op == 8'h58 || op == 8'h59) && rises >= 8'h08 |-> !miso_oe)
      else $error("output driven in refresh frame");
   a_no_early_out: assert property (miso_oe |-> rises >= 8'h08)
      else $error("output driven before opcode done");
   a_out_after_fall: assert property (miso_oe && $past(miso_oe) && $changed(miso) |-> !$past(sclk))
      else $error("output changed off the falling edge");
   a_mosi_hold_high: assert property (sclk && $past(sclk) |-> $stable(mosi))
      else $error("host data moved while clock high");
   a_byte_framing: assert property ($rose(cs_n) |-> rises[2:0] == 3'h0)
      else $error("frame not byte aligned");
   a_refresh_length: assert property ($rose(cs_n) && (op == 8'h58 || op == 8'h59) |-> rises == 8'h20)
      else $error("refresh frame length wrong");
   cover property ($rose(cs_n) && op == 8'h58);
   cover property ($rose(cs_n) && op == 8'h59);
   cover property ($rose(cs_n) && op == 8'hd7);
endmodule : fprs_sva

/* File: test/flash_page_refresh_and_status_tb_top.sv */
/* Bench for both link ends: register orders in, device outputs and status checked.
   Assumes host and device share core_clk. */
`timescale 1ns/1ps
`include "fprs_params.svh"
module flash_page_refresh_and_status_tb_top;
   localparam int unsigned RW = 200; // Long enough that a poll sees busy pairs first.
   localparam logic [3:0]  SC = 4'ha; // Arbitrary size code.
   logic core_clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, cdone = 1'b0, cmp = 1'b0;
   logic size = 1'b0, prot = 1'b0, abrt = 1'b0, flt = 1'b0, st, dn, bf, rmw, busy;
   logic [7:0]  addr = 8'h00;
   logic [10:0] pg;
   logic [31:0] wdata = 32'h0, rdata, d;
   int fails = 0, num_checks = 0, cyc = 0, len = 0, cnt = 0;
   fprs_link_if i_fprs_link_if ();
   fprs_device #(.REWRITE_CYCLES(RW), .SIZE_CODE(SC)) i_fprs_device (.core_clk(core_clk),
      .rst(rst), .link(i_fprs_link_if.dev), .page_size_256(size), .protect_enabled(prot),
      .array_abort(abrt), .array_fault(flt), .compare_busy(1'b0), .compare_done(cdone),
      .compare_mismatch(cmp), .refresh_start(st), .refresh_done(dn), .refresh_buffer(bf),
      .refresh_rmw(rmw), .refresh_page(pg), .busy(busy));
   fprs_host i_fprs_host (.core_clk(core_clk), .rst(rst), .link(i_fprs_link_if.host),
      .reg_addr(addr), .reg_wdata(wdata), .reg_write(wr), .reg_read(rd), .reg_rdata(rdata));
   fprs_sva i_fprs_sva (.core_clk(core_clk), .rst(rst), .sclk(i_fprs_link_if.sclk),
      .cs_n(i_fprs_link_if.cs_n), .mosi(i_fprs_link_if.mosi), .miso(i_fprs_link_if.miso),
      .miso_oe(i_fprs_link_if.miso_oe));
   always #2 core_clk = ~core_clk;
   // Measures start-to-done edges and cuts a hang short.
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      cnt <= st ? 0 : cnt + 1;
      if (dn) len <= cnt + 1;
      if (cyc == 20000) begin
         fails = fails + 1;
         wrap_up();
      end
   end
   task automatic wreg(input logic [7:0] a, input logic [31:0] v);
      @(posedge core_clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge core_clk);
      wr <= 1'b0;
   endtask : wreg
   // Read data stands only in the cycle after the strobe.
   task automatic rreg(input logic [7:0] a);
      @(posedge core_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge core_clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rreg
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wrap_up();
      if (fails == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : wrap_up
   // Each pass: refresh, status poll (while busy, except after the abort when i is 2), then the whole status pair.
   initial begin
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      rreg(8'hfc);
      chk(d, 32'h0);
      for (int i = 0; i < 4; i++) begin
         @(posedge core_clk);
         size <= i[1];
         prot <= i[0];
         flt <= (i == 1);
         abrt <= 1'b0;
         cmp <= !i[1];
         cdone <= 1'b1;
         @(posedge core_clk);
         cdone <= 1'b0;
         wreg(`FPRS_REG_PAGE, 32'h5a5 ^ i);
         wreg(`FPRS_REG_CTRL, {28'h0, i[1], i[0], 2'h1});
         for (int k = 0; k < 400 && st !== 1'b1; k++) @(negedge core_clk);
         chk({21'h0, pg}, 32'h5a5 ^ i);
         chk(bf, i[0]);
         chk(rmw, 1'b0);
         chk(busy, 1'b1);
         @(posedge core_clk);
         if (i == 2) abrt <= 1'b1;
         @(posedge core_clk);
         wreg(`FPRS_REG_CTRL, 32'h3);
         do rreg(`FPRS_REG_CTRL); while (d[0] !== 1'b0 && cyc < 20000);
         chk(busy, 1'b0);
         if (i != 2) chk(len, RW);
         rreg(`FPRS_REG_STATUS);
         chk(d[15:8], {1'b1, !i[1], SC, i[0], i[1]});
         chk(d[7:0], {2'h2, i == 1, 5'h0});
      end
      wrap_up();
   end
endmodule : flash_page_refresh_and_status_tb_top
